// *** verilog/swic_pkg.sv ***
// Purpose: shared constants and types for the wetting-current configuration registers
// Assumes: 24-bit register words, 6-bit register addresses from the serial front end
// Notes: field positions and reset values live here only
package swic_pkg;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 24;
	localparam int DIR_INPUTS = 10;
	localparam int LEVEL_INPUTS = 12;
	localparam int CODE_W = 3;

	// register addresses
	localparam logic [5:0] DIR_SEL_ADDR = 6'h1C;
	localparam logic [5:0] LEVEL_LOW_ADDR = 6'h1D;

	// reset values and writable-bit mask
	localparam logic [23:0] DIR_SEL_RESET = 24'h000000;
	localparam logic [23:0] LEVEL_LOW_RESET = 24'h000000;
	localparam logic [23:0] DIR_SEL_MASK = 24'h0003FF;

	// low bit of the level field that governs each input 0..11; pairs share a field
	localparam int unsigned INPUT_FIELD_LSB [12] = '{0, 0, 3, 3, 6, 9, 12, 12, 15, 15, 18, 21};

	// raw level codes
	localparam logic [2:0] CODE_OFF = 3'h0;
	localparam logic [2:0] CODE_1MA = 3'h1;
	localparam logic [2:0] CODE_2MA = 3'h2;
	localparam logic [2:0] CODE_5MA = 3'h3;
	localparam logic [2:0] CODE_10MA = 3'h4;

	typedef enum logic [2:0] {
		CUR_OFF = 3'h0,
		CUR_1MA = 3'h1,
		CUR_2MA = 3'h2,
		CUR_5MA = 3'h3,
		CUR_10MA = 3'h4,
		CUR_15MA = 3'h5
	} swic_current_type;

	typedef enum logic {
		DIR_SOURCE = 1'b0,
		DIR_SINK = 1'b1
	} swic_dir_type;

	// one register access from the serial front end
	typedef struct packed {
		logic write;
		logic read;
		logic [5:0] addr;
		logic [23:0] wdata;
	} swic_reg_req_type;

	// steering for one wetting-current generator
	typedef struct packed {
		logic enable;
		swic_current_type level;
		swic_dir_type dir;
	} swic_gen_drive_type;
endpackage

// *** verilog/swic_config_regs.sv ***
// Purpose: direction-select and lower-input level registers steering the wetting-current generators
// Assumes: the serial front end delivers decoded single-cycle register accesses on clk
// Notes: generator steering is taken from next-state values so it tracks the registers exactly

// Notes on behaviour
// - Bits 0..9 of the direction register pick source (0) or sink (1) for the same-numbered input.
// - Bits 23..10 of the direction register ignore writes and always read zero.
// - The 24-bit level register answers at address 0x1D and resets to zero.
// - A level code of zero turns off the wetting current for every input of its field.
// - Codes 1, 2, 3 and 4 select nominal 1, 2, 5 and 10 mA.
// - Codes 5, 6 and 7 all select the same nominal 15 mA setting.
// - Fields from the top are input 11, input 10, pair 8/9, pair 6/7, input 5 and input 4.
// - Bits 5..3 govern pair 2/3 and bits 2..0 pair 0/1, both inputs of a pair alike.
// - The direction register answers at address 0x1C and resets to zero.
module swic_config_regs (
	input wire logic clk, // 20 MHz system clock
	input wire logic rst, // asynchronous reset, active high
	input wire swic_pkg::swic_reg_req_type regReq, // register access strobes, address, data
	output logic [23:0] regRdata_q, // read data, valid with regRvalid_q
	output logic regRvalid_q, // one-cycle pulse after a read strobe
	output logic [9:0] dirSel_q, // direction select bits, 1 = sink
	output logic [23:0] levelLow_q, // stored level codes
	output swic_pkg::swic_gen_drive_type [11:0] genDrive_q // per-input generator steering
);
	logic [9:0] dirSel_d;
	logic [23:0] levelLow_d;
	logic [23:0] regRdata_d;
	logic regRvalid_d;
	swic_pkg::swic_gen_drive_type [11:0] genDrive_d;

	// level code to nominal current; three top codes collapse to one setting
	function automatic swic_pkg::swic_current_type decodeLevel(input logic [2:0] code);
		swic_pkg::swic_current_type cur;
		case (code)
			swic_pkg::CODE_OFF: cur = swic_pkg::CUR_OFF;
			swic_pkg::CODE_1MA: cur = swic_pkg::CUR_1MA;
			swic_pkg::CODE_2MA: cur = swic_pkg::CUR_2MA;
			swic_pkg::CODE_5MA: cur = swic_pkg::CUR_5MA;
			swic_pkg::CODE_10MA: cur = swic_pkg::CUR_10MA;
			default: cur = swic_pkg::CUR_15MA;
		endcase
		return cur;
	endfunction

	// register writes; a write to any other address changes nothing
	always_comb
	begin
		dirSel_d = dirSel_q;
		levelLow_d = levelLow_q;
		if (regReq.write && regReq.addr == swic_pkg::DIR_SEL_ADDR)
		begin
			// reserved bits are simply not stored, so nothing can leak back
			dirSel_d = regReq.wdata[9:0];
		end
		if (regReq.write && regReq.addr == swic_pkg::LEVEL_LOW_ADDR)
		begin
			levelLow_d = regReq.wdata;
		end
	end

	// read answer; unmapped addresses read zero so a host probing the map sees no stale data
	always_comb
	begin
		regRdata_d = regRdata_q;
		regRvalid_d = regReq.read;
		if (regReq.read)
		begin
			// reads return the stored value, not the write in the same cycle
			case (regReq.addr)
				swic_pkg::DIR_SEL_ADDR: regRdata_d = {14'h0000, dirSel_q};
				swic_pkg::LEVEL_LOW_ADDR: regRdata_d = levelLow_q;
				default: regRdata_d = 24'h000000;
			endcase
		end
	end

	// generator steering; pair inputs index the same field
	for (genvar i = 0; i < swic_pkg::LEVEL_INPUTS; i++)
	begin : g_drive
		localparam int unsigned LSB = swic_pkg::INPUT_FIELD_LSB[i];
		// inputs without a select bit point at bit 0, never at a bit past the register
		localparam int DIR_IDX = (i < swic_pkg::DIR_INPUTS) ? i : 0;
		always_comb
		begin
			genDrive_d[i].level = decodeLevel(levelLow_d[LSB +: 3]);
			genDrive_d[i].enable = (levelLow_d[LSB +: 3] != swic_pkg::CODE_OFF);
			if (i < swic_pkg::DIR_INPUTS)
			begin
				genDrive_d[i].dir = swic_pkg::swic_dir_type'(dirSel_d[DIR_IDX]);
			end
			else
			begin
				// inputs without a select bit stay on the source generator
				genDrive_d[i].dir = swic_pkg::DIR_SOURCE;
			end
		end
		// each steering word must follow its own stored fields on every cycle
		drive_track_a: assert property (@(posedge clk) disable iff (rst)
			genDrive_q[i].level == decodeLevel(levelLow_q[LSB +: 3])
			&& genDrive_q[i].dir == ((i < swic_pkg::DIR_INPUTS) ? dirSel_q[DIR_IDX] : 1'h0))
			else $error("steering word does not follow its stored fields");
	end

	// stored configuration; reset clears every field
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			dirSel_q <= swic_pkg::DIR_SEL_RESET[9:0];
			levelLow_q <= swic_pkg::LEVEL_LOW_RESET;
		end
		else
		begin
			dirSel_q <= dirSel_d;
			levelLow_q <= levelLow_d;
		end
	end

	// read answer registers; data holds until the next read so a slow host can still take it
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			regRdata_q <= 24'h000000;
			regRvalid_q <= 1'h0;
		end
		else
		begin
			regRdata_q <= regRdata_d;
			regRvalid_q <= regRvalid_d;
		end
	end

	// generator steering; fed from next-state values so it never lags the stored fields
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			genDrive_q <= '0;
		end
		else
		begin
			genDrive_q <= genDrive_d;
		end
	end

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// direction register: stores, steers and reads back
	dir_write_a: assert property (
		regReq.write && regReq.addr == swic_pkg::DIR_SEL_ADDR
		|=> dirSel_q == $past(regReq.wdata[9:0]) && genDrive_q[9].dir == dirSel_q[9])
		else $error("direction select not stored or not steering");
	reserved_read_a: assert property (
		regReq.read && regReq.addr == swic_pkg::DIR_SEL_ADDR
		|=> regRvalid_q && regRdata_q[23:10] == 14'h0000)
		else $error("reserved direction bits read nonzero");
	dir_read_a: assert property (
		regReq.read && regReq.addr == swic_pkg::DIR_SEL_ADDR
		|=> regRdata_q[9:0] == $past(dirSel_q))
		else $error("direction register read wrong");

	// level register: stores and reads back
	level_write_a: assert property (
		regReq.write && regReq.addr == swic_pkg::LEVEL_LOW_ADDR
		|=> levelLow_q == $past(regReq.wdata))
		else $error("level register write lost");
	level_read_a: assert property (
		regReq.read && regReq.addr == swic_pkg::LEVEL_LOW_ADDR
		|=> regRdata_q == $past(levelLow_q))
		else $error("level register read wrong");

	// code decoding, one field each, so a swapped table entry shows up
	level_off_a: assert property (
		levelLow_q[2:0] == 3'h0
		|-> !genDrive_q[0].enable && !genDrive_q[1].enable)
		else $error("zero code left current on");
	code_one_a: assert property (
		levelLow_q[11:9] == 3'h1
		|-> genDrive_q[5].level == swic_pkg::CUR_1MA && genDrive_q[5].enable)
		else $error("code 1 did not select 1 mA");
	code_two_a: assert property (
		levelLow_q[8:6] == 3'h2
		|-> genDrive_q[4].level == swic_pkg::CUR_2MA && genDrive_q[4].enable)
		else $error("code 2 did not select 2 mA");
	level_map_a: assert property (
		levelLow_q[23:21] == 3'h3
		|-> genDrive_q[11].level == swic_pkg::CUR_5MA && genDrive_q[11].enable)
		else $error("code 3 did not select 5 mA");
	code_ten_a: assert property (
		levelLow_q[17:15] == 3'h4
		|-> genDrive_q[8].level == swic_pkg::CUR_10MA && genDrive_q[9].level == swic_pkg::CUR_10MA)
		else $error("code 4 did not select 10 mA");
	top_codes_a: assert property (
		levelLow_q[20:18] >= 3'h5
		|-> genDrive_q[10].level == swic_pkg::CUR_15MA)
		else $error("top code did not select 15 mA");

	// field placement and pairing
	field_place_a: assert property (
		genDrive_q[5].enable == (levelLow_q[11:9] != 3'h0)
		&& genDrive_q[4].enable == (levelLow_q[8:6] != 3'h0))
		else $error("single-input field misplaced");
	pair_upper_a: assert property (
		genDrive_q[6].level == genDrive_q[7].level
		&& genDrive_q[8].level == genDrive_q[9].level)
		else $error("upper pair inputs differ");
	pair_equal_a: assert property (
		genDrive_q[2].level == genDrive_q[3].level
		&& genDrive_q[2].level == decodeLevel(levelLow_q[5:3]))
		else $error("pair inputs differ");
	pair_low_a: assert property (
		genDrive_q[0].level == genDrive_q[1].level
		&& genDrive_q[0].level == decodeLevel(levelLow_q[2:0]))
		else $error("lowest pair inputs differ");

	// holding behaviour and the read answer
	hold_value_a: assert property (
		!regReq.write
		|=> $stable(dirSel_q) && $stable(levelLow_q))
		else $error("register changed without a write");
	stray_write_a: assert property (
		regReq.write && regReq.addr != swic_pkg::DIR_SEL_ADDR
		&& regReq.addr != swic_pkg::LEVEL_LOW_ADDR |=> $stable(dirSel_q) && $stable(levelLow_q))
		else $error("unmapped write changed a register");
	read_answer_a: assert property (
		regReq.read
		|=> regRvalid_q)
		else $error("read not answered");
	read_hold_a: assert property (
		!regReq.read
		|=> !regRvalid_q && $stable(regRdata_q))
		else $error("read answer changed without a read");
	stray_read_a: assert property (
		regReq.read && regReq.addr != swic_pkg::DIR_SEL_ADDR
		&& regReq.addr != swic_pkg::LEVEL_LOW_ADDR |=> regRdata_q == 24'h000000)
		else $error("unmapped read returned nonzero");

	dir_write_c: cover property (regReq.write && regReq.addr == swic_pkg::DIR_SEL_ADDR);
	top_code_c: cover property (levelLow_q[14:12] == 3'h6);
	level_read_c: cover property (regReq.read && regReq.addr == swic_pkg::LEVEL_LOW_ADDR
		##1 regRvalid_q);
	sink_on_c: cover property (genDrive_q[8].dir == swic_pkg::DIR_SINK && genDrive_q[8].enable);
	stray_write_c: cover property (regReq.write && regReq.addr != swic_pkg::DIR_SEL_ADDR
		&& regReq.addr != swic_pkg::LEVEL_LOW_ADDR);
endmodule

// *** tb/swic_host_model.sv ***
// Purpose: host model issuing single-cycle register accesses
// Assumes: strobes launched on the falling edge, answer one cycle later
// Notes: idle address and data are inverted so stale values never match
module swic_host_model (
	input wire logic clk, // system clock
	input wire logic [23:0] regRdata_q, // read data from the block
	input wire logic regRvalid_q, // read answer pulse
	output swic_pkg::swic_reg_req_type regReq // access toward the block
);
	timeunit 1ns;
	timeprecision 1ns;
	initial regReq = '0;
	// one access; the answer pulse stands one cycle, so it is sampled right away
	task automatic access(input logic wr, input logic [5:0] a, input logic [23:0] d,
		output logic [23:0] q, output logic ok);
		@(negedge clk);
		regReq = '{write: wr, read: !wr, addr: a, wdata: d};
		@(negedge clk);
		regReq = '{write: 1'b0, read: 1'b0, addr: ~a, wdata: ~d};
		ok = wr | regRvalid_q;
		q = regRdata_q;
	endtask
endmodule

// *** tb/swic_testbench.sv ***
// Purpose: self-checking bench for the config registers
// Assumes: host model drives all accesses on the falling edge
// Notes: expectations come from field layout, not from the block
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst = 1'b1;
	swic_pkg::swic_reg_req_type regReq;
	logic [23:0] regRdata_q;
	logic regRvalid_q;
	logic [9:0] dirSel_q;
	logic [23:0] levelLow_q;
	swic_pkg::swic_gen_drive_type [11:0] genDrive_q;
	int fails = 0;
	int comparisons = 0;
	logic [23:0] rd;
	logic ok;
	logic [2:0] lv;
	logic [2:0] expLv [12] = '{3'h5, 3'h5, 3'h5, 3'h5, 3'h0, 3'h5, 3'h4, 3'h4, 3'h3, 3'h3, 3'h2, 3'h1};
	always #25 clk = ~clk;
	swic_config_regs swic_config_regs_i (.clk(clk), .rst(rst), .regReq(regReq),
		.regRdata_q(regRdata_q), .regRvalid_q(regRvalid_q), .dirSel_q(dirSel_q),
		.levelLow_q(levelLow_q), .genDrive_q(genDrive_q));
	swic_host_model swic_host_model_i (.clk(clk), .regRdata_q(regRdata_q),
		.regRvalid_q(regRvalid_q), .regReq(regReq));
	// single compare point
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [5:0] a, input logic [23:0] d);
		swic_host_model_i.access(1'b1, a, d, rd, ok);
	endtask
	// a missing answer pulse counts as a mismatch too
	task automatic rdchk(input logic [5:0] a, input logic [23:0] e);
		swic_host_model_i.access(1'b0, a, 24'h000000, rd, ok);
		check(24'(ok), 24'h000001);
		check(rd, e);
	endtask
	task automatic test_reset();
		check(levelLow_q, 24'h000000);
		check(24'(dirSel_q), 24'h000000);
		rdchk(6'h1C, 24'h000000);
		rdchk(6'h1D, 24'h000000);
		$display("test reset done");
	endtask
	task automatic test_direction();
		wr(6'h1C, 24'hFFFFFF);
		check(24'(dirSel_q), 24'h0003FF);
		check(24'(genDrive_q[9].dir), 24'h000001);
		check(24'({genDrive_q[11].dir, genDrive_q[10].dir}), 24'h000000);
		rdchk(6'h1C, 24'h0003FF);
		wr(6'h1C, 24'hC00155);
		check(24'(genDrive_q[1].dir), 24'h000000);
		rdchk(6'h1C, 24'h000155);
		$display("test direction done");
	endtask
	// every code into every field at once
	task automatic test_codes();
		for (int c = 0; c < 8; c++)
		begin
			wr(6'h1D, {8{3'(c)}});
			lv = (c > 4) ? 3'h5 : 3'(c);
			for (int i = 0; i < 12; i++)
			begin
				check(24'(genDrive_q[i].enable), 24'(c != 0));
				check(24'(genDrive_q[i].level), 24'(lv));
			end
			rdchk(6'h1D, {8{3'(c)}});
		end
		$display("test codes done");
	endtask
	// distinct codes show which field steers inputs 4 and 6..11; inputs 0..3 and 5 all decode to 15 mA
	task automatic test_layout();
		wr(6'h1D, {3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0, 3'h7, 3'h6});
		for (int i = 0; i < 12; i++)
			check(24'(genDrive_q[i].level), 24'(expLv[i]));
		wr(6'h1E, 24'hFFFFFF);
		check(levelLow_q, 24'h29CA3E);
		rdchk(6'h3F, 24'h000000);
		$display("test layout done");
	endtask
	// a reset in mid-run must clear both registers and all steering
	task automatic test_midreset();
		wr(6'h1C, 24'h0002AA);
		wr(6'h1D, 24'hFFFFFF);
		@(negedge clk);
		rst = 1'b1;
		repeat (2) @(negedge clk);
		check(24'(dirSel_q), 24'h000000);
		check(levelLow_q, 24'h000000);
		check(24'(|genDrive_q), 24'h000000);
		rst = 1'b0;
		rdchk(6'h1C, 24'h000000);
		rdchk(6'h1D, 24'h000000);
		$display("test midreset done");
	endtask
	initial
	begin
		repeat (20) @(negedge clk);
		rst = 1'b0;
		test_reset();
		test_direction();
		test_codes();
		test_layout();
		test_midreset();
		tally_and_finish();
	end
endmodule
